// file: cls_pkg.sv
`default_nettype none
package cls_pkg;
    // Location selector codes
    localparam logic [7:0] SEL_FIXED_PRIMARY   = 8'h00;
    localparam logic [7:0] SEL_FIXED_SECONDARY = 8'h01;
    localparam logic [7:0] SEL_ADAPTER_A_CW    = 8'h02;
    localparam logic [7:0] SEL_DIN_ONE         = 8'h03;
    localparam logic [7:0] SEL_DIN_TWO         = 8'h04;
    localparam logic [7:0] SEL_DIN_SIX         = 8'h08;
    localparam logic [7:0] SEL_TIMED_ONE       = 8'h13;
    localparam logic [7:0] SEL_TIMED_THREE     = 8'h15;
    localparam logic [7:0] SEL_SUPV_ONE        = 8'h19;
    localparam logic [7:0] SEL_SUPV_THREE      = 8'h1b;
    localparam logic [7:0] SEL_EMB_CW          = 8'h20;
    localparam int         CW_LOC_BIT          = 11;

    // Control mode codes
    localparam logic [2:0] MODE_NONE   = 3'h1;
    localparam logic [2:0] MODE_SPEED  = 3'h2;
    localparam logic [2:0] MODE_TORQUE = 3'h3;
    localparam logic [2:0] MODE_MIN    = 3'h4;
    localparam logic [2:0] MODE_MAX    = 3'h5;

    // Register map (word offsets as byte addresses)
    localparam logic [3:0] REG_LOC_SEL   = 4'h0;
    localparam logic [3:0] REG_MODE      = 4'h4;
    localparam logic [3:0] REG_STATUS    = 4'h8;
    localparam logic [3:0] REG_TORQUE    = 4'hc;
    localparam logic [7:0] RST_LOC_SEL   = 8'h00;
    localparam logic [2:0] RST_MODE      = MODE_SPEED;
    localparam int         ST_LOC_BIT    = 0;
    localparam int         ST_HOLD_BIT   = 1;
    localparam int         ST_MODE_LSB   = 4;

    typedef struct packed {
        logic [15:0] adapter_a_cw;
        logic [15:0] emb_cw;
        logic [5:0]  din_delayed;
        logic [2:0]  timed_status;
        logic [2:0]  supv_status;
    } cls_bits_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } cls_wb_req_t;
endpackage : cls_pkg
`default_nettype wire

// file: cls_torque_select.sv
`timescale 1ns/1ps
`default_nettype none
// Torque reference selector for the primary location
module cls_torque_select
    import cls_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_ce,
    input  wire logic [2:0]          i_mode,
    input  wire logic signed [W-1:0] i_speed_ctrl,
    input  wire logic signed [W-1:0] i_torque_ramp,
    input  wire logic signed [W-1:0] i_speed_err,
    output logic signed [W-1:0]      o_torque_ref,
    output logic                     o_hold
);
    logic signed [W-1:0] next_torque_ref;
    logic                next_hold;
    logic                err_neg;
    logic                err_pos;

    assign err_neg = i_speed_err < 0;
    assign err_pos = i_speed_err > 0;

    always_comb begin
        next_hold = 1'b0;
        next_torque_ref = i_speed_ctrl;
        case (i_mode)
            MODE_NONE:   next_torque_ref = '0;
            MODE_SPEED:  next_torque_ref = i_speed_ctrl;
            MODE_TORQUE: next_torque_ref = i_torque_ramp;
            MODE_MIN: begin
                // Latch onto speed loop until error turns back
                next_hold = err_neg | (o_hold & ~err_pos);
                if (next_hold)
                    next_torque_ref = i_speed_ctrl;
                else
                    next_torque_ref = (i_speed_ctrl < i_torque_ramp) ?
                                      i_speed_ctrl : i_torque_ramp;
            end
            MODE_MAX: begin
                next_hold = err_pos | (o_hold & ~err_neg);
                if (next_hold)
                    next_torque_ref = i_speed_ctrl;
                else
                    next_torque_ref = (i_speed_ctrl > i_torque_ramp) ?
                                      i_speed_ctrl : i_torque_ramp;
            end
            default: next_torque_ref = i_speed_ctrl;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_torque_ref <= '0;
            o_hold       <= 1'b0;
        end else if (i_ce) begin
            o_torque_ref <= next_torque_ref;
            o_hold       <= next_hold;
        end
    end

    AST_MIN_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && i_mode == MODE_MIN && err_neg |=> o_hold && o_torque_ref == $past(i_speed_ctrl))
        else $error("min mode did not follow speed loop");
    AST_MAX_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && i_mode == MODE_MAX && err_pos |=> o_hold && o_torque_ref == $past(i_speed_ctrl))
        else $error("max mode did not follow speed loop");
endmodule : cls_torque_select
`default_nettype wire

// file: cls_location_selector.sv
`timescale 1ns/1ps
`default_nettype none
module cls_location_selector
    import cls_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_ce,
    input  wire cls_bits_t           i_bits,
    input  wire logic signed [W-1:0] i_speed_ctrl,
    input  wire logic signed [W-1:0] i_torque_ramp,
    input  wire logic signed [W-1:0] i_speed_err,
    input  wire logic [31:0]         i_wb_adr,
    input  wire logic [31:0]         i_wb_dat,
    input  wire logic [3:0]          i_wb_sel,
    input  wire logic                i_wb_we,
    input  wire logic                i_wb_cyc,
    input  wire logic                i_wb_stb,
    output logic [31:0]              o_wb_dat,
    output logic                     o_wb_ack,
    output logic                     o_location_secondary,
    output logic signed [W-1:0]      o_torque_ref
);
    logic [7:0]          loc_sel;
    logic [2:0]          mode;
    logic                location_secondary;
    logic [7:0]          next_loc_sel;
    logic [2:0]          next_mode;
    logic                next_location;
    logic [31:0]         next_wb_dat;
    logic                next_wb_ack;
    logic                hold;
    logic                bus_req;

    function automatic logic pick_location(input logic [7:0] s, input cls_bits_t b,
                                           input logic cur);
        logic r;
        r = cur;
        if (s == SEL_FIXED_PRIMARY)
            r = 1'b0;
        else if (s == SEL_FIXED_SECONDARY)
            r = 1'b1;
        else if (s == SEL_ADAPTER_A_CW)
            r = b.adapter_a_cw[CW_LOC_BIT];
        else if (s >= SEL_DIN_ONE && s <= SEL_DIN_SIX)
            r = b.din_delayed[3'(s - SEL_DIN_ONE)];
        else if (s >= SEL_TIMED_ONE && s <= SEL_TIMED_THREE)
            r = b.timed_status[2'(s - SEL_TIMED_ONE)];
        else if (s >= SEL_SUPV_ONE && s <= SEL_SUPV_THREE)
            r = b.supv_status[2'(s - SEL_SUPV_ONE)];
        else if (s == SEL_EMB_CW)
            r = b.emb_cw[CW_LOC_BIT];
        return r;
    endfunction : pick_location

    // Unknown modes are refused so the selector never sees a bad code
    function automatic logic mode_valid(input logic [2:0] m);
        return m >= MODE_NONE && m <= MODE_MAX;
    endfunction : mode_valid

    assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

    always_comb begin
        next_loc_sel  = loc_sel;
        next_mode     = mode;
        next_wb_ack   = bus_req;
        next_wb_dat   = 32'h0000_0000;
        if (bus_req && i_wb_we && i_wb_sel[0]) begin
            if (i_wb_adr[3:0] == REG_LOC_SEL)
                next_loc_sel = i_wb_dat[7:0];
            else if (i_wb_adr[3:0] == REG_MODE && mode_valid(i_wb_dat[2:0]))
                next_mode = i_wb_dat[2:0];
        end
        if (bus_req && !i_wb_we) begin
            case (i_wb_adr[3:0])
                REG_LOC_SEL: next_wb_dat = {24'h00_0000, loc_sel};
                REG_MODE:    next_wb_dat = {29'h0000_0000, mode};
                REG_STATUS: begin
                    next_wb_dat[ST_LOC_BIT]                  = location_secondary;
                    next_wb_dat[ST_HOLD_BIT]                 = hold;
                    next_wb_dat[ST_MODE_LSB+2:ST_MODE_LSB]   = mode;
                end
                REG_TORQUE:  next_wb_dat = 32'(o_torque_ref);
                default:     next_wb_dat = 32'h0000_0000;
            endcase
        end
        next_location = pick_location(loc_sel, i_bits, location_secondary);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            loc_sel            <= RST_LOC_SEL;
            mode               <= RST_MODE;
            location_secondary <= 1'b0;
            o_wb_ack           <= 1'b0;
            o_wb_dat           <= 32'h0000_0000;
        end else if (i_ce) begin
            loc_sel            <= next_loc_sel;
            mode               <= next_mode;
            location_secondary <= next_location;
            o_wb_ack           <= next_wb_ack;
            o_wb_dat           <= next_wb_dat;
        end
    end

    assign o_location_secondary = location_secondary;

    cls_torque_select #(
        .W(W)
    ) cls_torque_select_inst (
        .i_sys_clk    (i_sys_clk),
        .i_reset_n    (i_reset_n),
        .i_ce         (i_ce),
        .i_mode       (mode),
        .i_speed_ctrl (i_speed_ctrl),
        .i_torque_ramp(i_torque_ramp),
        .i_speed_err  (i_speed_err),
        .o_torque_ref (o_torque_ref),
        .o_hold       (hold)
    );

    sequence s_sel_emb;
        i_ce && loc_sel == SEL_EMB_CW;
    endsequence

    // Refused mode write still completes on the bus
    sequence s_bad_mode_write;
        i_ce && bus_req && i_wb_we && i_wb_sel[0] && i_wb_adr[3:0] == REG_MODE
            && !mode_valid(i_wb_dat[2:0]);
    endsequence

    sequence s_bus_taken;
        i_ce && bus_req;
    endsequence

    // Compare path only: no hold now and none about to be set
    sequence s_min_compare;
        i_ce && mode == MODE_MIN && !hold && i_speed_err >= 0;
    endsequence

    sequence s_max_compare;
        i_ce && mode == MODE_MAX && !hold && i_speed_err <= 0;
    endsequence

    AST_FIXED_PRI: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_FIXED_PRIMARY |=> !o_location_secondary)
        else $error("fixed primary not honoured");
    AST_FIXED_SEC: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_FIXED_SECONDARY |=> o_location_secondary)
        else $error("fixed secondary not honoured");
    AST_ADAPTER: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_ADAPTER_A_CW
        |=> o_location_secondary == $past(i_bits.adapter_a_cw[CW_LOC_BIT]))
        else $error("adapter control bit not followed");
    AST_DIN_ONE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_DIN_ONE |=> o_location_secondary == $past(i_bits.din_delayed[0]))
        else $error("input one not followed");
    AST_DIN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_DIN_TWO |=> o_location_secondary == $past(i_bits.din_delayed[1]))
        else $error("input two not followed");
    AST_DIN_SIX: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_DIN_SIX |=> o_location_secondary == $past(i_bits.din_delayed[5]))
        else $error("input six not followed");
    AST_TIMED: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_TIMED_THREE
        |=> o_location_secondary == $past(i_bits.timed_status[2]))
        else $error("timed bit not followed");
    AST_TIMED_ONE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_TIMED_ONE
        |=> o_location_secondary == $past(i_bits.timed_status[0]))
        else $error("first timed bit not followed");
    AST_SUPV: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_SUPV_ONE |=> o_location_secondary == $past(i_bits.supv_status[0]))
        else $error("supervision bit not followed");
    AST_SUPV_THREE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel == SEL_SUPV_THREE
        |=> o_location_secondary == $past(i_bits.supv_status[2]))
        else $error("third supervision bit not followed");
    AST_EMB: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_sel_emb |=> o_location_secondary == $past(i_bits.emb_cw[11]))
        else $error("embedded control bit not followed");
    AST_UNLISTED: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && loc_sel > SEL_DIN_SIX && loc_sel < SEL_TIMED_ONE
        |=> $stable(o_location_secondary))
        else $error("unlisted code moved location");
    AST_NONE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && mode == MODE_NONE |=> o_torque_ref == '0)
        else $error("none mode not zero");
    AST_MODE_REFUSED: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_bad_mode_write |=> $stable(mode) && o_wb_ack)
        else $error("bad mode code accepted");
    AST_SPEED: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && mode == MODE_SPEED |=> o_torque_ref == $past(i_speed_ctrl))
        else $error("speed mode wrong reference");
    AST_TORQUE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && mode == MODE_TORQUE |=> o_torque_ref == $past(i_torque_ramp))
        else $error("torque mode wrong reference");
    AST_MIN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_min_compare
        |=> o_torque_ref <= $past(i_speed_ctrl) && o_torque_ref <= $past(i_torque_ramp))
        else $error("min mode not smaller");
    AST_MAX: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_max_compare
        |=> o_torque_ref >= $past(i_speed_ctrl) && o_torque_ref >= $past(i_torque_ramp))
        else $error("max mode not greater");
    AST_ACK_ANSWER: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_bus_taken |=> o_wb_ack)
        else $error("bus request not answered");
    AST_ACK_PULSE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_RDAT_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        i_ce && !(bus_req && !i_wb_we) |=> o_wb_dat == '0)
        else $error("read data outside a read");
    // Clock enable low must freeze location, torque reference, mode, selector and bus ack
    AST_CE_FREEZE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        !i_ce |=> $stable(o_location_secondary) && $stable(o_torque_ref)
            && $stable(o_wb_ack) && $stable(mode) && $stable(loc_sel))
        else $error("state moved with clock enable low");
    AST_RESET: assert property (@(posedge i_sys_clk)
        !i_reset_n |=> mode == MODE_SPEED && !o_location_secondary)
        else $error("reset state wrong");
endmodule : cls_location_selector
`default_nettype wire

// file: cls_drive_chain_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side speed and torque chains: levels held until the bench moves them
module cls_drive_chain_model #(
    parameter int W = 16
) (
    output var logic signed [W-1:0] o_speed_ctrl,
    output var logic signed [W-1:0] o_torque_ramp,
    output var logic signed [W-1:0] o_speed_err
);
    initial begin
        o_speed_ctrl  = '0;
        o_torque_ramp = '0;
        o_speed_err   = '0;
    end

    // Call only just after a rising edge, so the block sees a clean level
    task automatic drive(input logic signed [W-1:0] spd, trq, err);
        o_speed_ctrl  <= spd;
        o_torque_ramp <= trq;
        o_speed_err   <= err;
    endtask : drive
endmodule : cls_drive_chain_model
`default_nettype wire

// file: tb_control_location_torque_selector.sv
`timescale 1ns/1ps
`default_nettype none
module tb_control_location_torque_selector;
    import cls_pkg::*;
    logic               clk, rst_n, ce, we, cyc, stb, ack, loc;
    cls_bits_t          bits;
    logic [31:0]        adr, dat, rd, q;
    logic [3:0]         sel;
    logic signed [15:0] tq;
    wire logic signed [15:0] spd, trq, err;
    int                 miscompares, cmp_count, cycles;

    cls_drive_chain_model #(.W(16)) chain (.o_speed_ctrl(spd), .o_torque_ramp(trq),
        .o_speed_err(err));
    cls_location_selector #(.W(16)) cls_location_selector_inst (.i_sys_clk(clk),
        .i_reset_n(rst_n), .i_ce(ce), .i_bits(bits), .i_speed_ctrl(spd),
        .i_torque_ramp(trq), .i_speed_err(err), .i_wb_adr(adr), .i_wb_dat(dat),
        .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rd),
        .o_wb_ack(ack), .o_location_secondary(loc), .o_torque_ref(tq));

    always #12.5 clk = ~clk;

    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Generous ceiling, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Values read right after an edge are those the edge sampled
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        adr <= {28'h0, a}; dat <= d; we <= w; sel <= 4'hf; cyc <= 1'b1; stb <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb

    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    function automatic cls_bits_t pick(input logic [7:0] c, input logic v);
        cls_bits_t b;
        b = v ? '0 : '1;
        case (c) inside
            8'h02: b.adapter_a_cw[CW_LOC_BIT] = v;
            [8'h03:8'h08]: b.din_delayed[c - 8'h03] = v;
            [8'h13:8'h15]: b.timed_status[c - 8'h13] = v;
            [8'h19:8'h1b]: b.supv_status[c - 8'h19] = v;
            8'h20: b.emb_cw[CW_LOC_BIT] = v;
            default: ;
        endcase
        return b;
    endfunction : pick

    task automatic reset_vals;
        @(posedge clk);
        chk("location", {31'h0, loc}, 32'h0);
        chk("torque", 32'(tq), 32'h0);
        wb(REG_LOC_SEL, 1'b0, '0); chk("loc_sel", q, 32'(RST_LOC_SEL));
        wb(REG_MODE, 1'b0, '0); chk("mode", q, 32'(MODE_SPEED));
        wb(4'h2, 1'b0, '0); chk("unmapped", q, 32'h0);
    endtask : reset_vals

    task automatic loc_codes;
        logic [7:0] codes [17];
        codes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                  8'h13, 8'h14, 8'h15, 8'h19, 8'h1a, 8'h1b, 8'h20, 8'h20};
        for (int i = 0; i < 17; i++) begin
            for (int v = 0; v < 2; v++) begin
                wb(REG_LOC_SEL, 1'b1, 32'(codes[i]));
                bits <= pick(codes[i], v[0]);
                settle();
                chk("location", {31'h0, loc}, codes[i] < 2 ? 32'(codes[i]) : 32'(v));
            end
        end
        // Unlisted code keeps the last location
        wb(REG_LOC_SEL, 1'b1, 32'h9);
        bits <= '0;
        settle();
        chk("location_hold", {31'h0, loc}, 32'h1);
        wb(REG_STATUS, 1'b0, '0);
        chk("status_location", 32'(q[ST_LOC_BIT]), 32'h1);
    endtask : loc_codes

    task automatic step(input logic signed [15:0] s, t, e, x);
        @(posedge clk);
        chain.drive(s, t, e);
        settle();
        chk("torque", 32'(tq), 32'(x));
    endtask : step

    task automatic mode_chk(input logic [2:0] m, input logic signed [15:0] s, t, e, x);
        wb(REG_MODE, 1'b1, 32'(m));
        step(s, t, e, x);
        wb(REG_STATUS, 1'b0, '0);
        chk("status_mode", 32'(q[6:4]), 32'(m));
        wb(REG_TORQUE, 1'b0, '0);
        chk("torque_reg", q, 32'(x));
    endtask : mode_chk

    // Error sign chosen so min and max end on their compare path; max holds briefly on the +5 error left from the torque check
    task automatic modes;
        mode_chk(MODE_SPEED, 16'sd100, -16'sd50, 16'sd5, 16'sd100);
        mode_chk(MODE_TORQUE, 16'sd100, -16'sd50, 16'sd5, -16'sd50);
        mode_chk(MODE_MAX, -16'sd20, 16'sd70, -16'sd5, 16'sd70);
        mode_chk(MODE_NONE, 16'sd100, -16'sd50, 16'sd5, 16'sd0);
        wb(REG_MODE, 1'b1, 32'h7);
        wb(REG_MODE, 1'b0, '0); chk("mode_refused", q, 32'(MODE_NONE));
        mode_chk(MODE_MIN, 16'sd100, -16'sd50, 16'sd5, -16'sd50);
    endtask : modes

    task automatic hold_min_max;
        step(16'sd200, 16'sd50, -16'sd1, 16'sd200);
        step(16'sd200, 16'sd50, 16'sd0, 16'sd200);
        wb(REG_STATUS, 1'b0, '0);
        chk("status_hold", 32'(q[ST_HOLD_BIT]), 32'h1);
        step(16'sd200, 16'sd50, 16'sd1, 16'sd50);
        wb(REG_MODE, 1'b1, 32'(MODE_MAX));
        step(-16'sd100, 16'sd30, 16'sd1, -16'sd100);
        step(-16'sd100, 16'sd30, 16'sd0, -16'sd100);
        step(-16'sd100, 16'sd30, -16'sd1, 16'sd30);
    endtask : hold_min_max

    // Max mode left active: torque must stay frozen while enable is low
    task automatic ce_freeze;
        @(posedge clk);
        ce <= 1'b0;
        chain.drive(16'sd7, 16'sd7, 16'sd0);
        settle();
        chk("torque_frozen", 32'(tq), 32'(16'sd30));
        ce <= 1'b1;
        settle();
        chk("torque_run", 32'(tq), 32'h7);
    endtask : ce_freeze

    initial begin
        clk = 1'b0; rst_n = 1'b0; ce = 1'b1; bits = '0; adr = '0; dat = '0;
        sel = '0; we = 1'b0; cyc = 1'b0; stb = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        reset_vals();
        loc_codes();
        modes();
        hold_min_max();
        ce_freeze();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reset_vals();
        tally_and_finish();
    end
endmodule : tb_control_location_torque_selector
`default_nettype wire
